//--- verilog/hdr_regs.sv
`timescale 1ns/1ps
module hdr_regs
    import hdr_pkg::*;
(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // apb slave
    input  wire logic              psel_in,
    input  wire logic              penable_in,
    input  wire logic              pwrite_in,
    input  wire logic [ADDR_W-1:0] paddr_in,
    input  wire logic [DATA_W-1:0] pwdata_in,
    input  wire logic [3:0]        pstrb_in,
    output logic      [DATA_W-1:0] prdata_out,
    output logic                   pready_out,
    output logic                   pslverr_out,
    // device status sources
    input  wire logic              clock_input_two_selected_in,
    input  wire logic              dac_low_in,
    input  wire logic              dac_high_in,
    input  wire logic              readback_data_in,
    input  wire logic              primary_loop_locked_in,
    input  wire logic [9:0]        tuning_code_in,
    input  wire logic              track_update_in,
    input  wire logic              holdover_request_in,
    input  wire logic              clock_input_activity_in,
    // reset pin
    input  wire logic              reset_pin_in,
    output logic                   reset_pin_out,
    output logic                   reset_pin_oe_out,
    output logic                   reset_pin_pullup_out,
    output logic                   reset_pin_pulldown_out,
    // device control outputs
    output logic                   reset_request_out,
    output logic                   holdover_out,
    output logic [9:0]             dac_code_out,
    output logic                   dac_locked_out,
    output logic                   clock_switch_out,
    output logic                   irq_out
);

    // ========================================================================
    // decode helpers
    // ========================================================================
    function automatic logic reg_known(input logic [IDX_W-1:0] idx);
        reg_known = (idx == IDX_RESET_PIN) || (idx == IDX_HOLDOVER) ||
                    (idx == IDX_MANUAL_DAC_VALUE_LOW) || (idx == IDX_IRQ_STATUS) ||
                    (idx == IDX_IRQ_MASK) || (idx == IDX_DAC_STATUS);
    endfunction

    function automatic logic [LOSS_CNT_W-1:0] loss_limit(input logic [1:0] sel);
        case (sel)
            2'h0:    loss_limit = LOSS_CNT_W'(LOSS_CYC_5M);
            2'h1:    loss_limit = LOSS_CNT_W'(LOSS_CYC_25M);
            2'h2:    loss_limit = LOSS_CNT_W'(LOSS_CYC_100M);
            default: loss_limit = LOSS_CNT_W'(LOSS_CYC_200M);
        endcase
    endfunction

    function automatic logic pin_is_input(input logic [2:0] t);
        pin_is_input = (t == IO_INPUT) || (t == IO_PULLUP) || (t == IO_PULLDOWN);
    endfunction

    // ========================================================================
    // register storage
    // ========================================================================
    hdr_holdover_t          holdover_ctrl;
    hdr_reset_pin_t         reset_pin_cfg;
    logic [7:0]             manual_dac_low;
    logic [IRQ_W-1:0]       irq_status;
    logic [IRQ_W-1:0]       irq_mask;
    logic [9:0]             tracked_dac;
    hdr_apb_state_t         apb_state;

    logic [IDX_W-1:0]       bus_idx;
    logic                   bus_ok;
    logic                   wr_commit;
    logic [DATA_W-1:0]      rd_value;
    logic [9:0]             manual_dac_value;
    logic                   next_holdover;
    logic                   tracking_active;
    logic [IRQ_W-1:0]       irq_event;
    logic [IRQ_W-1:0]       irq_clear;

    assign bus_idx          = paddr_in[ADDR_W-1:2];
    assign bus_ok           = (paddr_in[1:0] == 2'h0) && reg_known(bus_idx);
    // a write lands only at the edge that completes the access phase
    assign wr_commit        = psel_in && penable_in && pready_out && pwrite_in &&
                              bus_ok && pstrb_in[0];
    assign manual_dac_value = {holdover_ctrl.manual_dac_high, manual_dac_low};

    always_comb begin
        rd_value = '0;
        case (bus_idx)
            IDX_RESET_PIN:   rd_value[7:0] = {2'h0, reset_pin_cfg[5:0]};
            IDX_HOLDOVER:    rd_value[7:0] = holdover_ctrl;
            IDX_MANUAL_DAC_VALUE_LOW: rd_value[7:0] = manual_dac_low;
            IDX_IRQ_STATUS:  rd_value[IRQ_W-1:0] = irq_status;
            IDX_IRQ_MASK:    rd_value[IRQ_W-1:0] = irq_mask;
            IDX_DAC_STATUS: begin
                rd_value[9:0]         = dac_code_out;
                rd_value[ST_HOLDOVER] = holdover_out;
                rd_value[ST_TRACKING] = tracking_active;
                rd_value[ST_PIN_RESET] = reset_request_out;
            end
            default:         rd_value = '0;
        endcase
    end

    // ========================================================================
    // apb slave: one wait state, answer registered
    // ========================================================================
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            apb_state   <= APB_IDLE;
            pready_out  <= 1'b0;
            prdata_out  <= '0;
            pslverr_out <= 1'b0;
        end else begin
            case (apb_state)
                APB_IDLE: begin
                    pready_out  <= 1'b0;
                    pslverr_out <= 1'b0;
                    if (psel_in && penable_in) begin
                        apb_state   <= APB_ANSWER;
                        pready_out  <= 1'b1;
                        pslverr_out <= !bus_ok;
                        prdata_out  <= (bus_ok && !pwrite_in) ? rd_value : '0;
                    end
                end
                APB_ANSWER: begin
                    apb_state   <= APB_IDLE;
                    pready_out  <= 1'b0;
                    pslverr_out <= 1'b0;
                end
                default: begin
                    apb_state  <= APB_IDLE;
                    pready_out <= 1'b0;
                end
            endcase
        end
    end

    // ========================================================================
    // control registers
    // ========================================================================
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            holdover_ctrl  <= HOLDOVER_RST;
            reset_pin_cfg  <= RESET_PIN_RST;
            manual_dac_low <= MANUAL_DAC_VALUE_LOW_RST;
            irq_mask       <= '0;
        end else if (wr_commit) begin
            case (bus_idx)
                IDX_HOLDOVER:    holdover_ctrl  <= pwdata_in[7:0];
                IDX_RESET_PIN:   reset_pin_cfg  <= {2'h0, pwdata_in[5:0]};
                IDX_MANUAL_DAC_VALUE_LOW: manual_dac_low <= pwdata_in[7:0];
                IDX_IRQ_MASK:    irq_mask       <= pwdata_in[IRQ_W-1:0];
                default:         irq_mask       <= irq_mask;
            endcase
        end
    end

    // ========================================================================
    // reset pin
    // ========================================================================
    logic pin_sync1;
    logic pin_sync2;
    logic pin_source;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pin_sync1 <= 1'b0;
            pin_sync2 <= 1'b0;
        end else begin
            pin_sync1 <= reset_pin_in;
            pin_sync2 <= pin_sync1;
        end
    end

    always_comb begin
        case (reset_pin_cfg.reset_pin_out_select)
            SEL_LOW:        pin_source = 1'b0;
            SEL_CLK_TWO:    pin_source = clock_input_two_selected_in;
            SEL_DAC_LOCKED: pin_source = dac_locked_out;
            SEL_DAC_LOW:    pin_source = dac_low_in;
            SEL_DAC_HIGH:   pin_source = dac_high_in;
            SEL_READBACK:   pin_source = readback_data_in;
            default:        pin_source = 1'b0;
        endcase
    end

    // reserved types leave the pin undriven and raise no reset
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reset_pin_out          <= 1'b0;
            reset_pin_oe_out       <= 1'b0;
            reset_pin_pullup_out   <= 1'b0;
            reset_pin_pulldown_out <= 1'b1;
        end else begin
            reset_pin_pullup_out   <= (reset_pin_cfg.io_type == IO_PULLUP);
            reset_pin_pulldown_out <= (reset_pin_cfg.io_type == IO_PULLDOWN);
            case (reset_pin_cfg.io_type)
                IO_PUSH_PULL: begin
                    reset_pin_out    <= pin_source;
                    reset_pin_oe_out <= 1'b1;
                end
                IO_PUSH_INV: begin
                    reset_pin_out    <= !pin_source;
                    reset_pin_oe_out <= 1'b1;
                end
                IO_OPEN_DRAIN: begin
                    reset_pin_out    <= 1'b0;
                    reset_pin_oe_out <= !pin_source;
                end
                default: begin
                    reset_pin_out    <= 1'b0;
                    reset_pin_oe_out <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reset_request_out <= 1'b0;
        end else begin
            reset_request_out <= pin_is_input(reset_pin_cfg.io_type) && pin_sync2;
        end
    end

    // ========================================================================
    // holdover and dac
    // ========================================================================
    assign next_holdover   = holdover_ctrl.force_holdover || holdover_request_in;
    // tracking freezes in holdover so the last tracked code is kept
    assign tracking_active = holdover_ctrl.track_enable && primary_loop_locked_in &&
                             !next_holdover;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || reset_request_out) begin
            tracked_dac <= TRACK_START;
        end else if (tracking_active && track_update_in) begin
            tracked_dac <= tuning_code_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            holdover_out   <= 1'b0;
            dac_code_out   <= TRACK_START;
            dac_locked_out <= 1'b0;
        end else begin
            holdover_out   <= next_holdover;
            dac_locked_out <= tracking_active;
            if (next_holdover && holdover_ctrl.manual_dac_enable) begin
                dac_code_out <= manual_dac_value;
            end else begin
                dac_code_out <= tracked_dac;
            end
        end
    end

    // ========================================================================
    // signal-loss timeout
    // ========================================================================
    logic [LOSS_CNT_W-1:0] loss_count;
    logic                  loss_fired;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            loss_count       <= '0;
            loss_fired       <= 1'b0;
            clock_switch_out <= 1'b0;
        end else begin
            clock_switch_out <= 1'b0;
            if (!holdover_ctrl.signal_loss_enable || clock_input_activity_in) begin
                loss_count <= '0;
                loss_fired <= 1'b0;
            end else if (!loss_fired) begin
                if (loss_count + 1'b1 >= loss_limit(holdover_ctrl.signal_loss_timeout)) begin
                    loss_fired       <= 1'b1;
                    clock_switch_out <= 1'b1;
                end else begin
                    loss_count <= loss_count + 1'b1;
                end
            end
        end
    end

    // ========================================================================
    // interrupts: sticky, write one to clear, set wins
    // ========================================================================
    assign irq_event[IRQ_LOSS]      = clock_switch_out;
    assign irq_event[IRQ_HOLDOVER]  = next_holdover && !holdover_out;
    assign irq_event[IRQ_PIN_RESET] = pin_is_input(reset_pin_cfg.io_type) && pin_sync2 &&
                                      !reset_request_out;
    assign irq_clear = (wr_commit && bus_idx == IDX_IRQ_STATUS) ?
                       pwdata_in[IRQ_W-1:0] : '0;

    for (genvar i = 0; i < IRQ_W; i++) begin : g_irq
        always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
                irq_status[i] <= 1'b0;
            end else if (irq_event[i]) begin
                irq_status[i] <= 1'b1;
            end else if (irq_clear[i]) begin
                irq_status[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status & irq_mask);
        end
    end

endmodule

//--- verilog/hdr_pkg.sv
package hdr_pkg;

    // ========================================================================
    // bus geometry
    // ========================================================================
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int IDX_W  = ADDR_W - 2;

    // ========================================================================
    // register indices (byte address = 4 * index)
    // ========================================================================
    localparam logic [IDX_W-1:0] IDX_RESET_PIN   = 10'h14A;
    localparam logic [IDX_W-1:0] IDX_HOLDOVER    = 10'h14B;
    localparam logic [IDX_W-1:0] IDX_MANUAL_DAC_VALUE_LOW = 10'h14C;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 10'h180;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 10'h181;
    localparam logic [IDX_W-1:0] IDX_DAC_STATUS  = 10'h182;

    // ========================================================================
    // field layouts and reset values
    // ========================================================================
    typedef struct packed {
        logic [1:0] signal_loss_timeout;
        logic       signal_loss_enable;
        logic       track_enable;
        logic       force_holdover;
        logic       manual_dac_enable;
        logic [1:0] manual_dac_high;
    } hdr_holdover_t;

    typedef struct packed {
        logic [1:0] reserved;
        logic [2:0] reset_pin_out_select;
        logic [2:0] io_type;
    } hdr_reset_pin_t;

    localparam logic [7:0] HOLDOVER_RST    = 8'h06;
    localparam logic [7:0] RESET_PIN_RST   = 8'h02;
    localparam logic [7:0] MANUAL_DAC_VALUE_LOW_RST = 8'h00;
    localparam logic [9:0] TRACK_START     = 10'h200;

    // reset pin io types
    localparam logic [2:0] IO_INPUT      = 3'h0;
    localparam logic [2:0] IO_PULLUP     = 3'h1;
    localparam logic [2:0] IO_PULLDOWN   = 3'h2;
    localparam logic [2:0] IO_PUSH_PULL  = 3'h3;
    localparam logic [2:0] IO_PUSH_INV   = 3'h4;
    localparam logic [2:0] IO_OPEN_DRAIN = 3'h6;

    // reset pin output sources
    localparam logic [2:0] SEL_LOW        = 3'h0;
    localparam logic [2:0] SEL_CLK_TWO    = 3'h2;
    localparam logic [2:0] SEL_DAC_LOCKED = 3'h3;
    localparam logic [2:0] SEL_DAC_LOW    = 3'h4;
    localparam logic [2:0] SEL_DAC_HIGH   = 3'h5;
    localparam logic [2:0] SEL_READBACK   = 3'h6;

    // dac status word layout
    localparam int ST_HOLDOVER  = 10;
    localparam int ST_TRACKING  = 11;
    localparam int ST_PIN_RESET = 12;

    // interrupt bits
    localparam int IRQ_W         = 3;
    localparam int IRQ_LOSS      = 0;
    localparam int IRQ_HOLDOVER  = 1;
    localparam int IRQ_PIN_RESET = 2;

    // ========================================================================
    // signal-loss timeouts: about two periods of the named input rate
    // ========================================================================
    localparam int CLK_MHZ      = 125;
    localparam int LOSS_NS_5M   = 400;
    localparam int LOSS_NS_25M  = 80;
    localparam int LOSS_NS_100M = 20;
    localparam int LOSS_NS_200M = 10;
    localparam int LOSS_CYC_5M   = (LOSS_NS_5M * CLK_MHZ + 999) / 1000;
    localparam int LOSS_CYC_25M  = (LOSS_NS_25M * CLK_MHZ + 999) / 1000;
    localparam int LOSS_CYC_100M = (LOSS_NS_100M * CLK_MHZ + 999) / 1000;
    localparam int LOSS_CYC_200M = (LOSS_NS_200M * CLK_MHZ + 999) / 1000;
    localparam int LOSS_CNT_W    = 6;

    typedef enum logic {APB_IDLE, APB_ANSWER} hdr_apb_state_t;

endpackage

//--- dv/hdr_regs_properties.sv
`timescale 1ns/1ps
module hdr_regs_properties
    import hdr_pkg::*;
(
    // clock and reset
    input wire logic              clk_in,
    input wire logic              sys_rst_in,
    // apb
    input wire logic              psel_in,
    input wire logic              penable_in,
    input wire logic [DATA_W-1:0] prdata_out,
    input wire logic              pready_out,
    input wire logic              pslverr_out,
    // reset pin
    input wire logic              reset_pin_in,
    input wire logic              reset_pin_oe_out,
    input wire logic              reset_pin_pullup_out,
    input wire logic              reset_pin_pulldown_out,
    input wire logic              reset_request_out,
    // holdover, dac and signal loss
    input wire logic              holdover_request_in,
    input wire logic              holdover_out,
    input wire logic [9:0]        dac_code_out,
    input wire logic              primary_loop_locked_in,
    input wire logic              clock_input_activity_in,
    input wire logic              clock_switch_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // ========================================================================
    // bus handshake
    // ========================================================================
    property p_ready_pulse; pready_out |=> !pready_out; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_wait_state; psel_in && !penable_in |-> ##2 pready_out; endproperty
    a_wait_state: assert property (p_wait_state) else $error("pready late");
    property p_err_ready; pslverr_out |-> pready_out; endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
    property p_rdata_upper; pready_out |-> prdata_out[31:13] == 19'h0; endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper bits set");

    // ========================================================================
    // reset pin
    // ========================================================================
    property p_no_pull_drive;
        reset_pin_oe_out |-> !(reset_pin_pullup_out || reset_pin_pulldown_out);
    endproperty
    a_no_pull_drive: assert property (p_no_pull_drive) else $error("pull on driven pin");
    property p_pin_request; $rose(reset_request_out) |-> $past(reset_pin_in, 3); endproperty
    a_pin_request: assert property (p_pin_request) else $error("request without pin");

    // ========================================================================
    // holdover, tracking, signal loss
    // ========================================================================
    property p_track_start;
        reset_request_out ##1 (reset_request_out && !holdover_out)
            |=> dac_code_out == TRACK_START;
    endproperty
    a_track_start: assert property (p_track_start) else $error("no restart code");
    property p_holdover_req; holdover_request_in |=> holdover_out; endproperty
    a_holdover_req: assert property (p_holdover_req) else $error("no holdover");
    property p_track_freeze;
        (!primary_loop_locked_in && !holdover_out && !reset_request_out)[*3]
            |-> $stable(dac_code_out);
    endproperty
    a_track_freeze: assert property (p_track_freeze) else $error("code moved unlocked");
    property p_switch_pulse; clock_switch_out |=> !clock_switch_out; endproperty
    a_switch_pulse: assert property (p_switch_pulse) else $error("switch held");
    property p_switch_idle; clock_switch_out |-> !$past(clock_input_activity_in); endproperty
    a_switch_idle: assert property (p_switch_idle) else $error("switch while active");

    c_pin_request: cover property (reset_request_out);
    c_switch: cover property (clock_switch_out);
    c_bus_error: cover property (pslverr_out);
endmodule

bind hdr_regs hdr_regs_properties u_props (
    .clk_in, .sys_rst_in, .psel_in, .penable_in, .prdata_out, .pready_out, .pslverr_out,
    .reset_pin_in, .reset_pin_oe_out, .reset_pin_pullup_out, .reset_pin_pulldown_out,
    .reset_request_out, .holdover_request_in, .holdover_out, .dac_code_out,
    .primary_loop_locked_in, .clock_input_activity_in, .clock_switch_out
);

//--- dv/hdr_regs_bench.sv
`timescale 1ns/1ps
module hdr_regs_bench
    import hdr_pkg::*;
;
    logic              clk_in = 1'b0;
    logic              sys_rst_in = 1'b1;
    logic              psel_in = 1'b0;
    logic              penable_in = 1'b0;
    logic              pwrite_in = 1'b0;
    logic [ADDR_W-1:0] paddr_in = '0;
    logic [DATA_W-1:0] pwdata_in = '0;
    logic [3:0]        pstrb_in = 4'hF;
    logic              locked = 1'b0;
    logic              upd = 1'b0;
    logic              hreq = 1'b0;
    logic              act = 1'b1;
    logic              pin_drv = 1'b0;
    logic [9:0]        tune = 10'h000;
    logic [DATA_W-1:0] prdata_out;
    logic              pready_out, pslverr_out, reset_pin_out, reset_pin_oe_out;
    logic              reset_pin_pullup_out, reset_pin_pulldown_out, reset_request_out;
    logic              holdover_out, dac_locked_out, clock_switch_out, irq_out;
    logic [9:0]        dac_code_out;
    wire               reset_pin_in;
    int                n_mismatch = 0;
    int                compares = 0;
    int                k;
    int                loss_n [4] = '{LOSS_CYC_5M, LOSS_CYC_25M, LOSS_CYC_100M, LOSS_CYC_200M};
    logic [2:0]        otype [3] = '{3'h3, 3'h4, 3'h6};
    logic [2:0]        itype [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h7};
    // sources: input-two 1, dac low 1, dac high 0, readback 1, tracking off
    logic [6:0]        src_tab = 7'b1010100;

    // pin: block level while it drives, else bench level
    assign reset_pin_in = reset_pin_oe_out ? reset_pin_out : pin_drv;
    always #4 clk_in = ~clk_in;

    hdr_regs DUT (
        .clk_in, .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
        .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
        .clock_input_two_selected_in(1'b1), .dac_low_in(1'b1), .dac_high_in(1'b0),
        .readback_data_in(1'b1), .primary_loop_locked_in(locked), .tuning_code_in(tune),
        .track_update_in(upd), .holdover_request_in(hreq), .clock_input_activity_in(act),
        .reset_pin_in, .reset_pin_out, .reset_pin_oe_out, .reset_pin_pullup_out,
        .reset_pin_pulldown_out, .reset_request_out, .holdover_out, .dac_code_out,
        .dac_locked_out, .clock_switch_out, .irq_out
    );

    // ========================================================================
    // helpers
    // ========================================================================
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    task automatic chk(input logic [31:0] got, exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        int n;
        n = 0;
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (n >= 16) begin
            n_mismatch++;
            stop_test();
        end
        q = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        @(posedge clk_in);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
        chk(e, exp_err);
    endtask

    task automatic pulse();
        upd <= 1'b1;
        @(posedge clk_in);
        upd <= 1'b0;
        cyc(3);
    endtask

    task automatic stop_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(20000);
        n_mismatch++;
        stop_test();
    end

    // ========================================================================
    // main sequence
    // ========================================================================
    initial begin
        cyc(5);
        sys_rst_in <= 1'b0;
        cyc(2);
        rd(12'h528, 32'h02, 1'b0);
        rd(12'h52C, 32'h06, 1'b0);
        rd(12'h530, 32'h00, 1'b0);
        rd(12'h608, 32'h200, 1'b0);
        chk(reset_pin_pulldown_out, 32'h1);
        $display("test reset values done");
        wr(12'h528, 32'hFFFF_FFFF);
        rd(12'h528, 32'h3F, 1'b0);
        rd(12'h700, 32'h0, 1'b1);
        wr(12'h529, 32'h0);
        pstrb_in <= 4'hE;
        wr(12'h528, 32'h0);
        pstrb_in <= 4'hF;
        wr(12'h608, 32'h0);
        rd(12'h528, 32'h3F, 1'b0);
        rd(12'h608, 32'h200, 1'b0);
        $display("test refusals done");
        for (int i = 0; i < 3; i++) begin
            for (int s = 0; s < 7; s++) begin
                wr(12'h528, {26'h0, s[2:0], otype[i]});
                cyc(2);
                chk({reset_pin_oe_out, reset_pin_out}, (otype[i] == 3'h6) ?
                    {~src_tab[s], 1'b0} : {1'b1, src_tab[s] ^ (otype[i] == 3'h4)});
            end
        end
        for (int i = 0; i < 5; i++) begin
            wr(12'h528, {26'h0, 3'h6, itype[i]});
            cyc(2);
            chk({reset_pin_oe_out, reset_pin_pullup_out, reset_pin_pulldown_out},
                {1'b0, itype[i] == 3'h1, itype[i] == 3'h2});
        end
        $display("test pin types done");
        wr(12'h604, 32'h4);
        wr(12'h528, 32'h0);
        pin_drv <= 1'b1;
        cyc(5);
        chk(reset_request_out, 32'h1);
        rd(12'h608, 32'h1200, 1'b0);
        chk(irq_out, 32'h1);
        wr(12'h528, 32'h5);
        cyc(5);
        chk(reset_request_out, 32'h0);
        pin_drv <= 1'b0;
        wr(12'h600, 32'h4);
        cyc(2);
        chk(irq_out, 32'h0);
        rd(12'h600, 32'h0, 1'b0);
        $display("test pin reset done");
        wr(12'h52C, 32'h10);
        locked <= 1'b1;
        tune <= 10'h155;
        pulse();
        chk({dac_locked_out, dac_code_out}, 11'h555);
        rd(12'h608, 32'h955, 1'b0);
        locked <= 1'b0;
        tune <= 10'h0AA;
        pulse();
        chk({dac_locked_out, dac_code_out}, 11'h155);
        locked <= 1'b1;
        wr(12'h52C, 32'h18);
        cyc(2);
        chk(holdover_out, 32'h1);
        tune <= 10'h2F0;
        pulse();
        chk(dac_code_out, 32'h155);
        rd(12'h600, 32'h2, 1'b0);
        chk(irq_out, 32'h0);
        wr(12'h530, 32'h34);
        wr(12'h52C, 32'h1F);
        cyc(2);
        chk(dac_code_out, 32'h334);
        wr(12'h52C, 32'h07);
        cyc(2);
        chk({holdover_out, dac_code_out}, {1'b0, 10'h155});
        hreq <= 1'b1;
        cyc(3);
        chk({holdover_out, dac_code_out}, {1'b1, 10'h334});
        hreq <= 1'b0;
        sys_rst_in <= 1'b1;
        cyc(2);
        sys_rst_in <= 1'b0;
        cyc(2);
        chk(dac_code_out, 32'h200);
        rd(12'h52C, 32'h06, 1'b0);
        $display("test holdover done");
        for (int t = 0; t < 4; t++) begin
            wr(12'h52C, {24'h0, t[1:0], 6'h26});
            act <= 1'b0;
            k = 0;
            do begin
                @(posedge clk_in);
                k++;
            end while (clock_switch_out !== 1'b1 && k < 80);
            chk(k, loss_n[t] + 1);
            act <= 1'b1;
        end
        rd(12'h600, 32'h1, 1'b0);
        wr(12'h52C, 32'h06);
        act <= 1'b0;
        k = 0;
        repeat (60) begin
            @(posedge clk_in);
            k += (clock_switch_out === 1'b1);
        end
        chk(k, 32'h0);
        act <= 1'b1;
        $display("test signal loss done");
        stop_test();
    end
endmodule
